// File: verilog/nas_defines.vh
// constants for the nibble alu skip datapath
`ifndef NAS_DEFINES_VH
`define NAS_DEFINES_VH
`define NAS_OP_W 5
`define NAS_OP_NOP 5'h00
`define NAS_OP_LOAD_IMM 5'h01
`define NAS_OP_TABLE_READ 5'h02
`define NAS_OP_ADD_MEM 5'h03
`define NAS_OP_ADD_MEM_CARRY 5'h04
`define NAS_OP_ADD_IMM 5'h05
`define NAS_OP_AND 5'h06
`define NAS_OP_OR 5'h07
`define NAS_OP_SET_CARRY 5'h08
`define NAS_OP_CLEAR_CARRY 5'h09
`define NAS_OP_SKIP_ZERO_CARRY 5'h0a
`define NAS_OP_COMPLEMENT 5'h0b
`define NAS_OP_ROTATE_RIGHT 5'h0c
`define NAS_OP_BIT_SET 5'h0d
`define NAS_OP_BIT_CLEAR 5'h0e
`define NAS_OP_BIT_TEST 5'h0f
`define NAS_OP_CMP_MEM 5'h10
`define NAS_OP_CMP_IMM 5'h11
`define NAS_ACC_RESET 4'h0
`define NAS_AUX_RESET 4'h0
`define NAS_CARRY_RESET 1'b0
`define NAS_TBL_ADDR_W 7
`define NAS_DR_LSB 4
`endif

// File: verilog/nas_adder.v
// four-bit adder with carry in and carry out
`timescale 1ns/1ps
module nas_adder
(
    input wire [3:0] i_a,
    input wire [3:0] i_b,
    input wire i_cin,
    output wire [3:0] o_sum,
    output wire o_cout
);
    wire [4:0] full;
    assign full = {1'b0, i_a} + {1'b0, i_b} + {4'h0, i_cin};
    assign o_sum = full[3:0];
    assign o_cout = full[4];
endmodule

// File: verilog/nas_bit_unit.v
// bit set, clear and test on one memory nibble
`timescale 1ns/1ps
module nas_bit_unit
(
    input wire [3:0] i_nibble,
    input wire [1:0] i_index,
    output wire [3:0] o_set,
    output wire [3:0] o_clear,
    output wire o_bit_zero
);
    wire [3:0] mask;
    assign mask = 4'h1 << i_index;
    assign o_set = i_nibble | mask;
    assign o_clear = i_nibble & ~mask;
    assign o_bit_zero = ~|(i_nibble & mask);
endmodule

// File: verilog/nas_datapath.v
// execution datapath of the four-bit core
//
// Function
// - load-immediate writes its immediate nibble into the accumulator
// - in a run of load-immediates only the first executes
// - table read: pattern bits 7-4 to aux, bits 3-0 to accumulator
// - table offset is three pointer bits above four accumulator bits
// - table read holds one return-stack level while running
// - add-memory adds memory nibble to accumulator, carry kept
// - add-memory-with-carry adds nibble and carry, carry out stored
// - add-immediate keeps carry, skips next when no overflow
// - and: accumulator becomes accumulator AND memory nibble
// - or: accumulator becomes accumulator OR memory nibble
// - set-carry forces carry to one only
// - clear-carry forces carry to zero only
// - skip-on-zero-carry skips when carry is zero, carry unchanged
// - complement inverts the accumulator
// - rotate-right shifts accumulator through carry
// - bit-set sets indexed memory bit, others kept
// - bit-clear clears indexed memory bit, others kept
// - bit-test skips next when indexed memory bit is zero
// - compare-memory skips when accumulator equals memory nibble
// - compare-immediate skips when accumulator equals immediate
//
`timescale 1ns/1ps
`include "nas_defines.vh"
module nas_datapath
(
    input wire i_core_clk,
    input wire i_rst,
    input wire i_op_valid,
    input wire [4:0] i_op,
    input wire i_op_last_word,
    input wire [3:0] i_imm,
    input wire [1:0] i_bit_index,
    input wire [2:0] i_table_page_index_bits,
    input wire [3:0] i_pointed_memory_nibble,
    input wire i_table_ack,
    input wire [7:0] i_table_pattern,
    output wire o_busy,
    output reg [3:0] o_acc,
    output reg [3:0] o_aux,
    output reg o_carry_flag,
    output reg o_skip_pending,
    output reg o_mem_we,
    output reg [3:0] o_mem_wdata,
    output reg o_table_req,
    output reg [6:0] o_table_addr,
    output reg o_stack_hold
);
    localparam ST_IDLE = 2'b01;
    localparam ST_TABLE = 2'b10;

    reg [1:0] state;
    reg [1:0] next_state;
    reg last_was_load;
    reg [3:0] next_acc;
    reg [3:0] next_aux;
    reg next_carry;
    reg next_skip;
    reg next_skip_pending;
    reg next_last_was_load;
    reg next_mem_we;
    reg [3:0] next_mem_wdata;
    reg next_table_req;
    reg [6:0] next_table_addr;
    reg next_stack_hold;
    reg execute;

    wire [3:0] add_mem_sum;
    wire add_mem_cout;
    wire [3:0] add_carry_sum;
    wire add_carry_cout;
    wire [3:0] add_imm_sum;
    wire add_imm_cout;
    wire [3:0] bit_set_val;
    wire [3:0] bit_clear_val;
    wire bit_zero;
    wire [3:0] and_val;
    wire [3:0] or_val;
    wire [3:0] rotate_val;
    wire mem_equal;
    wire imm_equal;

    assign and_val = o_acc & i_pointed_memory_nibble;
    assign or_val = o_acc | i_pointed_memory_nibble;
    // old carry enters the top, bit 0 leaves into the carry
    assign rotate_val = {o_carry_flag, o_acc[3:1]};
    assign mem_equal = (o_acc == i_pointed_memory_nibble);
    assign imm_equal = (o_acc == i_imm);

    nas_adder u_add_mem
    (
        .i_a(o_acc),
        .i_b(i_pointed_memory_nibble),
        .i_cin(1'b0),
        .o_sum(add_mem_sum),
        .o_cout(add_mem_cout)
    );

    nas_adder u_add_carry
    (
        .i_a(o_acc),
        .i_b(i_pointed_memory_nibble),
        .i_cin(o_carry_flag),
        .o_sum(add_carry_sum),
        .o_cout(add_carry_cout)
    );

    nas_adder u_add_imm
    (
        .i_a(o_acc),
        .i_b(i_imm),
        .i_cin(1'b0),
        .o_sum(add_imm_sum),
        .o_cout(add_imm_cout)
    );

    nas_bit_unit u_bits
    (
        .i_nibble(i_pointed_memory_nibble),
        .i_index(i_bit_index),
        .o_set(bit_set_val),
        .o_clear(bit_clear_val),
        .o_bit_zero(bit_zero)
    );

    // decoder must hold the next op while the table fetch is out
    assign o_busy = state[1];

    always @*
    begin
        next_state = state;
        next_acc = o_acc;
        next_aux = o_aux;
        next_carry = o_carry_flag;
        next_skip = 1'b0;
        next_skip_pending = o_skip_pending;
        next_last_was_load = last_was_load;
        next_mem_we = 1'b0;
        next_mem_wdata = o_mem_wdata;
        next_table_req = o_table_req;
        next_table_addr = o_table_addr;
        next_stack_hold = o_stack_hold;
        execute = 1'b0;
        case (state)
            ST_IDLE:
            begin
                if (i_op_valid)
                begin
                    if (o_skip_pending)
                    begin
                        // every word of the skipped op is swallowed
                        if (i_op_last_word)
                            next_skip_pending = 1'b0;
                        // a skipped load still continues the load run
                        next_last_was_load = (i_op == `NAS_OP_LOAD_IMM);
                    end
                    else if (i_op == `NAS_OP_LOAD_IMM && last_was_load)
                    begin
                        next_last_was_load = 1'b1;
                    end
                    else
                    begin
                        execute = 1'b1;
                        next_last_was_load = (i_op == `NAS_OP_LOAD_IMM);
                    end
                end
                if (execute)
                begin
                    case (i_op)
                        `NAS_OP_LOAD_IMM:
                            next_acc = i_imm;
                        `NAS_OP_TABLE_READ:
                        begin
                            next_table_addr = {i_table_page_index_bits,
                                o_acc};
                            next_table_req = 1'b1;
                            next_stack_hold = 1'b1;
                            next_state = ST_TABLE;
                        end
                        `NAS_OP_ADD_MEM:
                            next_acc = add_mem_sum;
                        `NAS_OP_ADD_MEM_CARRY:
                        begin
                            next_acc = add_carry_sum;
                            next_carry = add_carry_cout;
                        end
                        `NAS_OP_ADD_IMM:
                        begin
                            next_acc = add_imm_sum;
                            next_skip = ~add_imm_cout;
                        end
                        `NAS_OP_AND:
                            next_acc = and_val;
                        `NAS_OP_OR:
                            next_acc = or_val;
                        `NAS_OP_SET_CARRY:
                            next_carry = 1'b1;
                        `NAS_OP_CLEAR_CARRY:
                            next_carry = 1'b0;
                        `NAS_OP_SKIP_ZERO_CARRY:
                            next_skip = ~o_carry_flag;
                        `NAS_OP_COMPLEMENT:
                            next_acc = ~o_acc;
                        `NAS_OP_ROTATE_RIGHT:
                        begin
                            next_acc = rotate_val;
                            next_carry = o_acc[0];
                        end
                        `NAS_OP_BIT_SET:
                        begin
                            next_mem_we = 1'b1;
                            next_mem_wdata = bit_set_val;
                        end
                        `NAS_OP_BIT_CLEAR:
                        begin
                            next_mem_we = 1'b1;
                            next_mem_wdata = bit_clear_val;
                        end
                        `NAS_OP_BIT_TEST:
                            next_skip = bit_zero;
                        `NAS_OP_CMP_MEM:
                            next_skip = mem_equal;
                        `NAS_OP_CMP_IMM:
                            next_skip = imm_equal;
                        default:
                            next_skip = 1'b0;
                    endcase
                    if (next_skip)
                        next_skip_pending = 1'b1;
                end
            end
            ST_TABLE:
            begin
                // ops offered meanwhile are ignored: o_busy is high
                if (i_table_ack)
                begin
                    next_aux = i_table_pattern[7:4];
                    next_acc = i_table_pattern[3:0];
                    next_table_req = 1'b0;
                    next_stack_hold = 1'b0;
                    next_state = ST_IDLE;
                end
            end
            default:
                next_state = ST_IDLE;
        endcase
    end

    // one register per process keeps each reset value beside its use
    always @(posedge i_core_clk)
    begin
        if (i_rst)
            state <= ST_IDLE;
        else
            state <= next_state;
    end

    always @(posedge i_core_clk)
    begin
        if (i_rst)
            o_acc <= `NAS_ACC_RESET;
        else
            o_acc <= next_acc;
    end

    always @(posedge i_core_clk)
    begin
        if (i_rst)
            o_aux <= `NAS_AUX_RESET;
        else
            o_aux <= next_aux;
    end

    always @(posedge i_core_clk)
    begin
        if (i_rst)
            o_carry_flag <= `NAS_CARRY_RESET;
        else
            o_carry_flag <= next_carry;
    end

    // a skip left over from before reset must not eat the first op
    always @(posedge i_core_clk)
    begin
        if (i_rst)
            o_skip_pending <= 1'b0;
        else
            o_skip_pending <= next_skip_pending;
    end

    // cleared so the first load after reset always executes
    always @(posedge i_core_clk)
    begin
        if (i_rst)
            last_was_load <= 1'b0;
        else
            last_was_load <= next_last_was_load;
    end

    always @(posedge i_core_clk)
    begin
        if (i_rst)
            o_mem_we <= 1'b0;
        else
            o_mem_we <= next_mem_we;
    end

    always @(posedge i_core_clk)
    begin
        if (i_rst)
            o_mem_wdata <= 4'h0;
        else
            o_mem_wdata <= next_mem_wdata;
    end

    always @(posedge i_core_clk)
    begin
        if (i_rst)
            o_table_req <= 1'b0;
        else
            o_table_req <= next_table_req;
    end

    always @(posedge i_core_clk)
    begin
        if (i_rst)
            o_table_addr <= 7'h00;
        else
            o_table_addr <= next_table_addr;
    end

    // a reset mid-fetch releases the held stack level at once
    always @(posedge i_core_clk)
    begin
        if (i_rst)
            o_stack_hold <= 1'b0;
        else
            o_stack_hold <= next_stack_hold;
    end
endmodule

// File: bench/nas_datapath_monitor.sv
// assertion checker for the nibble alu datapath
`timescale 1ns/1ps
`include "nas_defines.vh"
module nas_datapath_monitor
(
    input wire i_core_clk,
    input wire i_rst,
    input wire i_op_valid,
    input wire [4:0] i_op,
    input wire i_op_last_word,
    input wire [3:0] i_imm,
    input wire [1:0] i_bit_index,
    input wire [2:0] i_table_page_index_bits,
    input wire [3:0] i_pointed_memory_nibble,
    input wire i_table_ack,
    input wire [7:0] i_table_pattern,
    input wire o_busy,
    input wire [3:0] o_acc,
    input wire [3:0] o_aux,
    input wire o_carry_flag,
    input wire o_skip_pending,
    input wire o_mem_we,
    input wire [3:0] o_mem_wdata,
    input wire o_table_req,
    input wire [6:0] o_table_addr,
    input wire o_stack_hold
);
    // an executed word: taken and not consumed by a skip
    wire take = i_op_valid && !o_busy && !o_skip_pending;
    default clocking @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);
    a_carry_set_one: assert property (
        take && i_op == `NAS_OP_SET_CARRY |=> o_carry_flag && $stable(o_acc))
        else $error("set carry wrong");
    a_rotate_through_carry: assert property (
        take && i_op == `NAS_OP_ROTATE_RIGHT |=> o_acc[2:0] == $past(o_acc[3:1])
        && o_acc[3] == $past(o_carry_flag) && o_carry_flag == $past(o_acc[0]))
        else $error("rotate wrong");
    a_add_imm_skip: assert property (
        take && i_op == `NAS_OP_ADD_IMM |=> o_acc == $past(o_acc) + $past(i_imm)
        && $stable(o_carry_flag) && o_skip_pending ==
        ({1'b0, $past(o_acc)} + {1'b0, $past(i_imm)} < 5'h10))
        else $error("add immediate wrong");
    a_zero_carry_skip: assert property (
        take && i_op == `NAS_OP_SKIP_ZERO_CARRY |=>
        o_skip_pending == !$past(o_carry_flag) && $stable(o_carry_flag))
        else $error("carry skip wrong");
    a_bit_set_write: assert property (
        take && i_op == `NAS_OP_BIT_SET |=> o_mem_we && o_mem_wdata ==
        ($past(i_pointed_memory_nibble) | 4'h1 << $past(i_bit_index)))
        else $error("bit set wrong");
    a_table_addr_hold: assert property (
        take && i_op == `NAS_OP_TABLE_READ |=> o_table_req && o_stack_hold
        && o_table_addr == {$past(i_table_page_index_bits), $past(o_acc)})
        else $error("table request wrong");
    a_table_load: assert property (
        o_table_req && i_table_ack |=> !o_stack_hold && !o_busy
        && {o_aux, o_acc} == $past(i_table_pattern))
        else $error("table load wrong");
    a_skip_no_change: assert property (
        i_op_valid && !o_busy && o_skip_pending && i_op_last_word |=>
        !o_skip_pending && !o_mem_we && $stable(o_acc) && $stable(o_aux))
        else $error("skipped word changed state");
endmodule
bind nas_datapath nas_datapath_monitor u_mon (.*);

// File: bench/nas_datapath_tb_top.sv
// self-checking bench for the nibble alu datapath
`timescale 1ns/1ps
`include "nas_defines.vh"
module nas_datapath_tb_top;
    logic i_core_clk = 0, i_rst = 1, i_op_valid = 0, i_op_last_word = 1;
    logic [4:0] i_op = 0;
    logic [3:0] i_imm = 0, i_pointed_memory_nibble = 0;
    logic [1:0] i_bit_index = 0;
    logic [2:0] i_table_page_index_bits = 0;
    logic i_table_ack = 0;
    logic [7:0] i_table_pattern = 0;
    wire o_busy, o_carry_flag, o_skip_pending, o_mem_we;
    wire o_table_req, o_stack_hold;
    wire [3:0] o_acc, o_aux, o_mem_wdata;
    wire [6:0] o_table_addr;
    // reference state kept by the driver
    logic [3:0] acc = 0, aux = 0;
    logic cy = 0, skp = 0, ld = 0, seen = 0;
    logic [14:0] q[$];
    logic [14:0] e;
    int fail_count = 0, n_compared = 0, k, c;
    nas_datapath DUT (.*);
    always #12.5 i_core_clk = ~i_core_clk;
    task automatic check(input logic [14:0] got, input logic [14:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        if (fail_count == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic op(input logic [4:0] o, input logic [3:0] n,
        input logic [1:0] j, input logic [3:0] m);
        logic [4:0] s;
        logic we, sk;
        logic [3:0] wd;
        s = 0; we = 0; sk = 0; wd = 0;
        @(posedge i_core_clk);
        i_op_valid <= 1; i_op <= o; i_imm <= n;
        i_bit_index <= j; i_pointed_memory_nibble <= m; i_op_last_word <= 1;
        if (!(skp || o == `NAS_OP_LOAD_IMM && ld))
            case (o)
                `NAS_OP_LOAD_IMM: acc = n;
                `NAS_OP_ADD_MEM: acc = acc + m;
                `NAS_OP_ADD_MEM_CARRY: {cy, acc} = acc + m + cy;
                `NAS_OP_ADD_IMM: {sk, acc} = {1'b0, acc} + n + 5'h10;
                `NAS_OP_AND: acc = acc & m;
                `NAS_OP_OR: acc = acc | m;
                `NAS_OP_SET_CARRY: cy = 1;
                `NAS_OP_CLEAR_CARRY: cy = 0;
                `NAS_OP_SKIP_ZERO_CARRY: sk = !cy;
                `NAS_OP_COMPLEMENT: acc = ~acc;
                `NAS_OP_ROTATE_RIGHT: {acc, cy} = {cy, acc};
                `NAS_OP_BIT_SET: {we, wd} = {1'b1, m | 4'h1 << j};
                `NAS_OP_BIT_CLEAR: {we, wd} = {1'b1, m & ~(4'h1 << j)};
                `NAS_OP_BIT_TEST: sk = !m[j];
                `NAS_OP_CMP_MEM: sk = acc == m;
                `NAS_OP_CMP_IMM: sk = acc == n;
                default: s = 0;
            endcase
        ld = o == `NAS_OP_LOAD_IMM;
        skp = sk;
        q.push_back({aux, acc, cy, skp, we, wd});
    endtask
    task automatic tbl(input logic [7:0] p, input logic [2:0] dr);
        int w;
        w = $urandom_range(0, 3);
        @(posedge i_core_clk);
        i_op_valid <= 1; i_op <= `NAS_OP_TABLE_READ;
        i_op_last_word <= 1; i_table_page_index_bits <= dr;
        q.push_back({aux, acc, cy, 6'h00});
        @(posedge i_core_clk);
        i_op <= `NAS_OP_COMPLEMENT;
        @(negedge i_core_clk);
        check({o_busy, o_stack_hold, o_table_req, o_table_addr},
            {5'h0, 3'h7, dr, acc});
        repeat (w) @(posedge i_core_clk);
        @(posedge i_core_clk);
        i_table_ack <= 1; i_table_pattern <= p; i_op_valid <= 0;
        {aux, acc} = p;
        skp = 0; ld = 0;
        q.push_back({aux, acc, cy, 6'h00});
        @(posedge i_core_clk);
        i_table_ack <= 0;
    endtask
    // results appear one cycle after a taken word or a taken answer
    always @(posedge i_core_clk)
        seen <= !i_rst && (i_op_valid && !o_busy || i_table_ack && o_table_req);
    always @(negedge i_core_clk)
    begin
        if (seen)
        begin
            e = q.pop_front();
            check({o_aux, o_acc, o_carry_flag, o_skip_pending, o_mem_we,
                o_mem_wdata & {4{e[4]}}}, e);
        end
    end
    initial
    begin
        repeat (20000) @(posedge i_core_clk);
        fail_count++;
        complete_run();
    end
    initial
    begin
        k = $urandom(85640);
        repeat (8) @(posedge i_core_clk);
        i_rst <= 0;
        @(negedge i_core_clk);
        check({o_aux, o_acc, o_carry_flag, o_skip_pending, o_busy}, 15'h0);
        for (k = 0; k < 400; k++)
        begin
            c = $urandom_range(0, 17);
            if (c == 2 && !skp)
                tbl(8'($urandom), 3'($urandom));
            else
                op(5'(c == 2 ? 0 : c), 4'($urandom), 2'($urandom),
                    4'($urandom));
        end
        for (k = 0; k < 3; k++)
            op(`NAS_OP_LOAD_IMM, 4'(k + 9), 2'h0, 4'h0);
        @(posedge i_core_clk);
        i_op_valid <= 0;
        repeat (3) @(posedge i_core_clk);
        complete_run();
    end
endmodule
